// File: rtl/flash_ctrl_defs.vh
// Constants for the flash erase, program timing and instruction cache control block.
// Notes on behaviour
// R1: Alias page-erase writes start ordinary page erase.
// R2: Write at 0x50c erases all user memory.
// R3: Write at 0x514 erases user configuration area.
// R4: Write at 0x518 starts one partial erase.
// R5: Partial duration in milliseconds, resets to ten.
// R6: Software repeats partial steps to reach 85 ms.
// R7: Partial step lasts duration times at most 1.05.
// R8: Cache bit0 enables, zero invalidates; bit8 profiles.
// R9: Hit counter counts hits; writes only clear.
// R10: Miss counter counts misses; writes only clear.
// R11: Software writes a word at most twice.
// R12: Word program finishes within 41 microseconds.
// R13: Page erase finishes within 85 milliseconds.
// R14: Erase all finishes within 169 milliseconds.
// R15: Counters advance while profiling, saturate at maximum.
// R16: Erase acts only while erase enabled.
// R17: Instruction fetch stalls during any erase.
// R18: Port lock blocks configuration area erase only.
// R19: Busy from acceptance to end; refuse while busy.
// R20: Trigger registers read zero without side effects.
`ifndef FLASH_CTRL_DEFS_VH
`define FLASH_CTRL_DEFS_VH

`define ADDR_W 12
`define OFF_READY 12'h400
`define OFF_CONFIG 12'h504
`define OFF_PAGE_ALIAS_A 12'h508
`define OFF_ERASE_ALL 12'h50c
`define OFF_PAGE_ALIAS_B 12'h510
`define OFF_UCFG_ERASE 12'h514
`define OFF_PARTIAL 12'h518
`define OFF_PARTIAL_DUR 12'h51c
`define OFF_CACHE_CFG 12'h540
`define OFF_HIT 12'h548
`define OFF_MISS 12'h54c

`define CFG_MODE_W 2
`define CFG_MODE_READ 2'h0
`define CFG_MODE_WRITE 2'h1
`define CFG_MODE_ERASE 2'h2
`define DUR_W 7
`define DUR_RESET 7'h0a
`define CACHE_ON_BIT 0
`define CACHE_PROF_BIT 8

`define OP_W 3
`define OP_NONE 3'h0
`define OP_WRITE 3'h1
`define OP_PAGE 3'h2
`define OP_ALL 3'h3
`define OP_UCFG 3'h4
`define OP_PARTIAL 3'h5

`define CLK_KHZ 25000
`define US_PER_MS 1000
`define T_WRITE_US 41
`define T_PAGE_ERASE_REQUEST_MS 85
`define T_ERASE_EVERYTHING_TRIGGER_MS 169
`define TIMER_W 32

`endif

// File: rtl/sat_counter.v
// Saturating event counter that software may only clear.
`timescale 1ns/100ps
module sat_counter #(
    parameter WIDTH = 32
) (
    input wire clk,
    input wire rst_n,
    input wire inc,
    input wire clr,
    output reg [WIDTH-1:0] count
);

    // Clear is a software write and has priority; the count stops at all ones.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= {WIDTH{1'b0}};
        end
        else if (clr)
        begin
            count <= {WIDTH{1'b0}};
        end
        // R15 saturate, no wrap
        else if (inc && (count != {WIDTH{1'b1}}))
        begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

endmodule // sat_counter

// File: rtl/op_timer.v
// Down counter that times one flash operation and reports when it ends.
`timescale 1ns/100ps
module op_timer #(
    parameter WIDTH = 32
) (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire [WIDTH-1:0] cycles,
    output wire running,
    output wire done
);

    reg [WIDTH-1:0] remain;

    // A zero load still runs one cycle so busy is always seen.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            remain <= {WIDTH{1'b0}};
        end
        else if (start)
        begin
            remain <= (cycles == {WIDTH{1'b0}}) ? {{(WIDTH-1){1'b0}}, 1'b1} : cycles;
        end
        else if (remain != {WIDTH{1'b0}})
        begin
            remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign running = (remain != {WIDTH{1'b0}});
    assign done = (remain == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule // op_timer

// File: rtl/flash_erase_cache_control.v
// APB controlled flash erase and program sequencer with instruction cache control.
`timescale 1ns/100ps
`include "flash_ctrl_defs.vh"
module flash_erase_cache_control #(
    parameter MS_CYCLES = `CLK_KHZ,
    parameter PAGE_ERASE_CYCLES = `T_PAGE_ERASE_REQUEST_MS * `CLK_KHZ,
    parameter ERASE_ALL_CYCLES = `T_ERASE_EVERYTHING_TRIGGER_MS * `CLK_KHZ
) (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire prog_req,
    input wire [31:0] prog_addr,
    output wire prog_ack,
    input wire access_port_lock,
    input wire cache_hit,
    input wire cache_miss,
    output reg [`OP_W-1:0] flash_op,
    output reg [31:0] flash_addr,
    output reg flash_start,
    output wire busy,
    output wire fetch_stall,
    output wire cache_on,
    output wire cache_profiling_on,
    output reg cache_invalidate
);

    // Erase lengths are parameters so a bench can shorten them; defaults are worst case.
    // Word program time is short, so it stays a fixed local count.
    localparam [`TIMER_W-1:0] WRITE_CYCLES = (`T_WRITE_US * `CLK_KHZ) / `US_PER_MS;
    localparam [`TIMER_W-1:0] PAGE_CYC = PAGE_ERASE_CYCLES;
    localparam [`TIMER_W-1:0] ALL_CYC = ERASE_ALL_CYCLES;
    localparam [`TIMER_W-1:0] MS_CYC = MS_CYCLES;

    // Register state, lock synchroniser and the launch decode.
    reg [`CFG_MODE_W-1:0] cfg_mode;
    reg [`DUR_W-1:0] partial_erase_duration;
    reg cache_en_bit;
    reg prof_en_bit;
    reg lock_s1;
    reg lock_s2;
    reg lock_s3;
    reg lock_q;
    reg [`OP_W-1:0] next_op;
    reg [`TIMER_W-1:0] next_cycles;
    reg addr_hit;
    // Internal nets.
    wire [31:0] hit_count;
    wire [31:0] miss_count;
    wire wr_access;
    wire erase_en;
    wire write_en;
    wire timer_running;
    wire timer_done;
    wire start_op;
    wire [`TIMER_W-1:0] partial_cycles;

    // Zero wait states: every access completes in its first access cycle.
    assign pready = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign pslverr = psel && penable && !addr_hit;

    // Address decode for the error answer on unmapped offsets.
    always @*
    begin
        case (paddr)
            `OFF_READY, `OFF_CONFIG, `OFF_PAGE_ALIAS_A, `OFF_ERASE_ALL,
            `OFF_PAGE_ALIAS_B, `OFF_UCFG_ERASE, `OFF_PARTIAL,
            `OFF_PARTIAL_DUR, `OFF_CACHE_CFG, `OFF_HIT, `OFF_MISS:
                addr_hit = 1'b1;
            default:
                addr_hit = 1'b0;
        endcase
    end

    // The lock pin is asynchronous; a new level counts once two later stages agree.
    // Resetting to locked keeps a configuration erase out until the pin has been seen.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_s1 <= 1'b1;
            lock_s2 <= 1'b1;
            lock_s3 <= 1'b1;
            lock_q <= 1'b1;
        end
        else
        begin
            lock_s1 <= access_port_lock;
            lock_s2 <= lock_s1;
            lock_s3 <= lock_s2;
            if (lock_s2 == lock_s3)
            begin
                lock_q <= lock_s3;
            end
        end
    end

    // Mode decode; config writes are refused while busy, so the mode holds for an operation.
    assign erase_en = (cfg_mode == `CFG_MODE_ERASE);
    assign write_en = (cfg_mode == `CFG_MODE_WRITE);
    assign busy = timer_running;

    // Limitation: the slower internal clock source is not modelled, only the crystal.
    // R7 unit step time is one millisecond of clocks, accuracy factor 1.0
    assign partial_cycles = {{(`TIMER_W-`DUR_W){1'b0}}, partial_erase_duration} * MS_CYC;

    // Choose the operation a bus write or program request would launch.
    // The partial step length uses the duration register as it stands at acceptance.
    always @*
    begin
        next_op = `OP_NONE;
        next_cycles = {`TIMER_W{1'b0}};
        if (!busy && wr_access && erase_en)
        begin
            case (paddr)
                // R1 alias page erase
                `OFF_PAGE_ALIAS_A, `OFF_PAGE_ALIAS_B:
                begin
                    next_op = `OP_PAGE;
                    // R13 page erase time
                    next_cycles = PAGE_CYC;
                end
                // R2 erase everything
                `OFF_ERASE_ALL:
                begin
                    next_op = `OP_ALL;
                    // R14 erase all time
                    next_cycles = ALL_CYC;
                end
                // R3 user config erase
                // R18 lock blocks this
                `OFF_UCFG_ERASE:
                begin
                    if (!lock_q)
                    begin
                        next_op = `OP_UCFG;
                        next_cycles = PAGE_CYC;
                    end
                end
                // R4 partial erase step
                `OFF_PARTIAL:
                begin
                    next_op = `OP_PARTIAL;
                    next_cycles = partial_cycles;
                end
                default:
                begin
                    next_op = `OP_NONE;
                end
            endcase
        end
        else if (!busy && !(psel && penable) && prog_req && write_en)
        begin
            // R12 word program time
            next_op = `OP_WRITE;
            next_cycles = WRITE_CYCLES;
        end
    end

    // Any APB access cycle, read or write, wins over the program port; the port simply holds its request.
    // R19 accept only when idle
    assign start_op = (next_op != `OP_NONE);
    assign prog_ack = start_op && (next_op == `OP_WRITE);

    // One shared timer: each operation kind loads its own length on acceptance.
    op_timer #(
        .WIDTH(`TIMER_W)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(start_op),
        .cycles(next_cycles),
        .running(timer_running),
        .done(timer_done)
    );

    // Latch the operation and its address for the array; the operation clears when the timer ends, the address holds.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flash_op <= `OP_NONE;
            flash_addr <= 32'h00000000;
            flash_start <= 1'b0;
        end
        else
        begin
            flash_start <= start_op;
            if (start_op)
            begin
                flash_op <= next_op;
                flash_addr <= (next_op == `OP_WRITE) ? prog_addr : pwdata;
            end
            else if (timer_done)
            begin
                flash_op <= `OP_NONE;
            end
        end
    end

    // A word program leaves fetches running; only the erase kinds hold the array.
    // R17 stall fetches during erase
    assign fetch_stall = busy && (flash_op != `OP_WRITE);

    // Writable configuration registers.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_mode <= `CFG_MODE_READ;
            partial_erase_duration <= `DUR_RESET;
            cache_en_bit <= 1'b0;
            prof_en_bit <= 1'b0;
            cache_invalidate <= 1'b0;
        end
        else
        begin
            cache_invalidate <= 1'b0;
            // R16 erase enable setting
            if (wr_access && (paddr == `OFF_CONFIG) && !busy)
            begin
                cfg_mode <= pwdata[`CFG_MODE_W-1:0];
            end
            // R5 duration field
            if (wr_access && (paddr == `OFF_PARTIAL_DUR))
            begin
                partial_erase_duration <= pwdata[`DUR_W-1:0];
            end
            // R8 cache enable and invalidate
            if (wr_access && (paddr == `OFF_CACHE_CFG))
            begin
                cache_en_bit <= pwdata[`CACHE_ON_BIT];
                prof_en_bit <= pwdata[`CACHE_PROF_BIT];
                cache_invalidate <= !pwdata[`CACHE_ON_BIT];
            end
        end
    end

    // Cache control levels go straight to the cache from their flip-flops.
    assign cache_on = cache_en_bit;
    assign cache_profiling_on = prof_en_bit;

    // Counting needs both the cache and profiling on; a write of any value clears.
    // R9 hit counter, clear only
    sat_counter #(
        .WIDTH(32)
    ) u_hit (
        .clk(clk),
        .rst_n(rst_n),
        .inc(cache_hit && cache_en_bit && prof_en_bit),
        .clr(wr_access && (paddr == `OFF_HIT)),
        .count(hit_count)
    );

    // R10 miss counter, clear only
    sat_counter #(
        .WIDTH(32)
    ) u_miss (
        .clk(clk),
        .rst_n(rst_n),
        .inc(cache_miss && cache_en_bit && prof_en_bit),
        .clr(wr_access && (paddr == `OFF_MISS)),
        .count(miss_count)
    );

    // Read data is registered during the setup cycle so it is stable in the access cycle.
    // Trigger registers and unmapped offsets read as zero; a read never starts anything.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h00000000;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `OFF_READY:
                    prdata <= {31'h00000000, !busy};
                `OFF_CONFIG:
                    prdata <= {30'h00000000, cfg_mode};
                `OFF_PARTIAL_DUR:
                    prdata <= {25'h0000000, partial_erase_duration};
                `OFF_CACHE_CFG:
                    prdata <= {23'h000000, prof_en_bit, 7'h00, cache_en_bit};
                `OFF_HIT:
                    prdata <= hit_count;
                `OFF_MISS:
                    prdata <= miss_count;
                // R20 triggers read zero
                default:
                    prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // flash_erase_cache_control

// File: tb/flash_ctrl_chk.sv
// Port assertions for the flash erase and cache control block.
`timescale 1ns/100ps
module flash_ctrl_chk #(
    parameter MS_CYCLES = 4,
    parameter PAGE_ERASE_CYCLES = 50,
    parameter ERASE_ALL_CYCLES = 90
) (
    input wire clk,
    input wire rst_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire pslverr,
    input wire prog_ack,
    input wire access_port_lock,
    input wire [2:0] flash_op,
    input wire [31:0] flash_addr,
    input wire flash_start,
    input wire busy,
    input wire fetch_stall,
    input wire cache_on,
    input wire cache_invalidate
);
    reg [31:0] run;
    reg [2:0] op;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Busy cycles are counted and the launched operation kept, to judge each length at its end.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run <= 32'h0;
            op <= 3'h0;
        end
        else
        begin
            run <= busy ? run + 32'h1 : 32'h0;
            if (flash_start)
                op <= flash_op;
        end
    end
    sequence launched;
        flash_start && busy;
    endsequence
    write_len_a: assert property ($fell(busy) && op == 3'h1 |-> run == 32'd1025)
        else $error("word program length wrong");
    page_len_a: assert property ($fell(busy) && op == 3'h2 |-> run == PAGE_ERASE_CYCLES)
        else $error("page erase length wrong");
    all_len_a: assert property ($fell(busy) && op == 3'h3 |-> run == ERASE_ALL_CYCLES)
        else $error("erase all length wrong");
    no_restart_a: assert property (busy && $past(busy) |-> !flash_start && $stable(flash_addr))
        else $error("request taken while busy");
    ack_launch_a: assert property (prog_ack |-> !busy ##1 launched ##0 flash_op == 3'h1)
        else $error("program request not launched");
    fetch_stall_a: assert property (fetch_stall == (busy && flash_op != 3'h1))
        else $error("fetch stall wrong");
    lock_block_a: assert property (flash_start && flash_op == 3'h4 |-> !$past(access_port_lock, 5))
        else $error("config erase under lock");
    cache_inval_a: assert property (psel && penable && pwrite && paddr == 12'h540 && !pwdata[0]
        |=> cache_invalidate && !cache_on)
        else $error("cache not invalidated");
    unmapped_err_a: assert property (psel && penable && paddr == 12'h000 |-> pslverr)
        else $error("unmapped access not flagged");
endmodule // flash_ctrl_chk

// File: tb/flash_erase_cache_control_tb.sv
// Self-checking bench for the flash erase and cache control block.
`timescale 1ns/100ps
module flash_erase_cache_control_tb;
    logic clk, rst_n, psel, penable, pwrite, prog_req, access_port_lock, cache_hit, cache_miss;
    logic [11:0] paddr;
    logic [31:0] pwdata, prog_addr, rd;
    logic err;
    wire [31:0] prdata, flash_addr;
    wire [2:0] flash_op;
    wire pready, pslverr, prog_ack, flash_start, busy, fetch_stall, cache_on, cache_prof, cache_inv;
    logic [76:0] rows [0:12];
    logic [46:0] ops [0:4];
    int err_count, checked, i;
    flash_erase_cache_control #(.MS_CYCLES(4), .PAGE_ERASE_CYCLES(50), .ERASE_ALL_CYCLES(90)) uut (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .prog_req(prog_req), .prog_addr(prog_addr), .prog_ack(prog_ack),
        .access_port_lock(access_port_lock), .cache_hit(cache_hit), .cache_miss(cache_miss),
        .flash_op(flash_op), .flash_addr(flash_addr), .flash_start(flash_start), .busy(busy),
        .fetch_stall(fetch_stall), .cache_on(cache_on), .cache_profiling_on(cache_prof),
        .cache_invalidate(cache_inv));
    // Free-running 25 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // The run needs about 1600 cycles; this cuts a hang short.
    initial
    begin
        #400000;
        err_count++;
        test_done;
    end
    task test_done;
        begin
            if (err_count == 0 && checked > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checked++;
            if (seen !== exp)
            begin
                err_count++;
                $display("wrong value at %0t: got %h want %h", $time, seen, exp);
            end
        end
    endtask
    // One APB transfer; an idle edge follows so the next call never reassigns psel in one step.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            do
                @(posedge clk);
            while (pready !== 1'b1);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Called one edge after acceptance; counts busy cycles at falling edges where all is settled.
    task run_op(input logic [2:0] op, input logic [31:0] a, input logic [31:0] n);
        int k;
        begin
            k = 0;
            @(negedge clk);
            chk(busy, 1'b1);
            chk(flash_op, op);
            chk(flash_addr, a);
            chk(fetch_stall, op != 3'h1);
            while (busy !== 1'b0 && k < 5000)
            begin
                @(negedge clk);
                k++;
            end
            chk(k, n);
            @(posedge clk);
        end
    endtask
    initial
    begin
        {rst_n, psel, penable, pwrite, prog_req, access_port_lock, cache_hit, cache_miss} = 8'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        prog_addr = 32'h0;
        err_count = 0;
        checked = 0;
        rows = '{{13'h51c, 64'ha}, {13'h540, 64'h0}, {13'h548, 64'h0}, {13'h54c, 64'h0},
            {13'h508, 64'h0}, {13'h50c, 64'h0}, {13'h510, 64'h0}, {13'h514, 64'h0},
            {13'h518, 64'h0}, {13'h151c, 64'h2_00000000}, {13'h51c, 64'h2},
            {13'h1540, 64'h101_00000000}, {13'h540, 64'h101}};
        ops = '{{12'h508, 3'h2, 32'd49}, {12'h510, 3'h2, 32'd49}, {12'h50c, 3'h3, 32'd89},
            {12'h514, 3'h4, 32'd49}, {12'h518, 3'h5, 32'd7}};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 13; i++)
        begin
            apb(rows[i][76], rows[i][75:64], rows[i][63:32]);
            if (!rows[i][76])
                chk(rd, rows[i][31:0]);
        end
        chk({cache_on, cache_prof}, 2'h3);
        cache_hit <= 1'b1;
        repeat (3) @(posedge clk);
        cache_hit <= 1'b0;
        cache_miss <= 1'b1;
        repeat (2) @(posedge clk);
        cache_miss <= 1'b0;
        apb(1'b0, 12'h548, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 12'h54c, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, 12'h548, 32'h1234);
        apb(1'b1, 12'h54c, 32'h5);
        apb(1'b0, 12'h548, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h54c, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h540, 32'h1);
        chk({cache_on, cache_prof}, 2'h2);
        cache_hit <= 1'b1;
        @(posedge clk);
        cache_hit <= 1'b0;
        apb(1'b0, 12'h548, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h540, 32'h0);
        chk(cache_on, 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h508, 32'h100);
        @(negedge clk);
        chk(busy, 1'b0);
        @(posedge clk);
        apb(1'b1, 12'h504, 32'h2);
        for (i = 0; i < 5; i++)
        begin
            apb(1'b1, ops[i][46:35], 32'h1000 + 32'(i));
            run_op(ops[i][34:32], 32'h1000 + 32'(i), ops[i][31:0]);
        end
        // Six more steps of eight cycles bring the page to 56 cycles, past its 50.
        for (i = 0; i < 6; i++)
        begin
            apb(1'b1, 12'h518, 32'h1004);
            run_op(3'h5, 32'h1004, 32'd7);
        end
        apb(1'b1, 12'h50c, 32'h9);
        apb(1'b1, 12'h508, 32'h77);
        run_op(3'h3, 32'h9, 32'd86);
        access_port_lock <= 1'b1;
        repeat (6) @(posedge clk);
        apb(1'b1, 12'h514, 32'h0);
        @(negedge clk);
        chk(busy, 1'b0);
        @(posedge clk);
        apb(1'b1, 12'h508, 32'h20);
        run_op(3'h2, 32'h20, 32'd49);
        access_port_lock <= 1'b0;
        apb(1'b1, 12'h504, 32'h1);
        prog_addr <= 32'h44;
        prog_req <= 1'b1;
        @(negedge clk);
        chk(prog_ack, 1'b1);
        @(posedge clk);
        prog_req <= 1'b0;
        @(posedge clk);
        run_op(3'h1, 32'h44, 32'd1024);
        apb(1'b1, 12'h504, 32'h2);
        apb(1'b1, 12'h508, 32'h30);
        rst_n <= 1'b0;
        @(negedge clk);
        chk({busy, flash_op}, 4'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h51c, 32'h0);
        chk(rd, 32'ha);
        test_done;
    end
endmodule // flash_erase_cache_control_tb
bind flash_erase_cache_control flash_ctrl_chk #(.MS_CYCLES(MS_CYCLES),
    .PAGE_ERASE_CYCLES(PAGE_ERASE_CYCLES), .ERASE_ALL_CYCLES(ERASE_ALL_CYCLES)) chk_i (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pslverr(pslverr), .prog_ack(prog_ack), .access_port_lock(access_port_lock),
    .flash_op(flash_op), .flash_addr(flash_addr), .flash_start(flash_start), .busy(busy),
    .fetch_stall(fetch_stall), .cache_on(cache_on), .cache_invalidate(cache_invalidate));
